/* File: core/fpkg_regs.svh */
// Purpose: Register offsets, field positions, key codes and timing counts
// Assumes: 20 MHz system clock, AXI4-Lite byte addresses
// Notes: Definitions only
`ifndef FPKG_REGS_SVH
`define FPKG_REGS_SVH

// Register byte offsets
`define FPKG_OFF_PROGRAM_STORE_CONTROL 8'h00
`define FPKG_OFF_KEY 8'h04
`define FPKG_OFF_SUPPLY 8'h08
`define FPKG_OFF_STATUS 8'h0c

// Program-store control fields and reset value
`define FPKG_PROGRAM_STORE_CONTROL_WE_BIT 0
`define FPKG_PROGRAM_STORE_CONTROL_EE_BIT 1
`define FPKG_PROGRAM_STORE_CONTROL_RESET 2'h0

// Supply monitor control fields and reset value
`define FPKG_SUP_EN_BIT 0
`define FPKG_SUP_RST_BIT 1
`define FPKG_SUPPLY_RESET 2'h0

// Status fields
`define FPKG_ST_BUSY_BIT 0
`define FPKG_ST_GATE_LSB 1
`define FPKG_ST_LOCK_BIT 3
`define FPKG_ST_FERR_BIT 4
`define FPKG_ST_INIT_BIT 5

// Key codes
`define FPKG_KEY_FIRST 8'ha5
`define FPKG_KEY_SECOND 8'hf1

// Flash geometry
`define FPKG_PAGE_BYTES 1024
`define FPKG_FLASH_BYTES 4096
`define FPKG_ERASED_BYTE 8'hff

// Operation timing
`define FPKG_CLK_MHZ 20
`define FPKG_WRITE_TIME_NS 40000
`define FPKG_ERASE_TIME_NS 20000000
`define FPKG_WRITE_CYCLES ((`FPKG_WRITE_TIME_NS * `FPKG_CLK_MHZ + 999) / 1000)
`define FPKG_ERASE_CYCLES ((`FPKG_ERASE_TIME_NS * `FPKG_CLK_MHZ + 999) / 1000)

// AXI response codes
`define FPKG_RESP_OKAY 2'h0
`define FPKG_RESP_SLVERR 2'h2

`endif

/* File: core/fpkg_pkg.sv */
// Purpose: Shared types of the flash key gate
// Assumes: Nothing beyond the header
// Notes: Numbers live in fpkg_regs.svh
`default_nettype none
package fpkg_pkg;
  // Key gate states
  typedef enum logic [1:0] {
    FPKG_IDLE,
    FPKG_FIRST_SEEN,
    FPKG_UNLOCKED,
    FPKG_LOCKED_OUT
  } fpkg_gate_state_t;

  // Kind of flash operation under way
  typedef enum logic {
    FPKG_OP_PROGRAM,
    FPKG_OP_ERASE
  } fpkg_op_t;
endpackage
`default_nettype wire

/* File: core/fpkg_gate_if.sv */
// Purpose: Carrier between the sequencer and its key gate
// Assumes: Single system clock
// Notes: Pulses are one cycle wide
`default_nettype none
interface fpkg_gate_if;
  import fpkg_pkg::*;
  logic key_wr;
  logic [7:0] key_val;
  logic attempt;
  logic done;
  logic unlocked;
  fpkg_gate_state_t state;

  modport gate (input key_wr, input key_val, input attempt, input done,
    output unlocked, output state);
  modport seq (output key_wr, output key_val, output attempt, output done,
    input unlocked, input state);
endinterface
`default_nettype wire

/* File: core/fpkg_key_gate.sv */
// Purpose: Two-code key gate for software flash operations
// Assumes: Key writes and attempts are one-cycle pulses
// Notes: Lockout lasts until system reset
`include "fpkg_regs.svh"
`default_nettype none
module fpkg_key_gate
  import fpkg_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sequencer side
  fpkg_gate_if.gate g
);
  fpkg_gate_state_t state_r;
  fpkg_gate_state_t state_nxt;

  // Next state; order and value are checked, never spacing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FPKG_IDLE: begin
        if (g.attempt) begin
          state_nxt = FPKG_LOCKED_OUT;
        end else if (g.key_wr) begin
          state_nxt = (g.key_val == `FPKG_KEY_FIRST) ? FPKG_FIRST_SEEN
                                                    : FPKG_LOCKED_OUT;
        end
      end
      FPKG_FIRST_SEEN: begin
        if (g.attempt) begin
          state_nxt = FPKG_LOCKED_OUT;
        end else if (g.key_wr) begin
          state_nxt = (g.key_val == `FPKG_KEY_SECOND) ? FPKG_UNLOCKED
                                                     : FPKG_LOCKED_OUT;
        end
      end
      FPKG_UNLOCKED: begin
        if (g.key_wr) begin
          state_nxt = FPKG_LOCKED_OUT;
        end else if (g.done) begin
          state_nxt = FPKG_IDLE;
        end
      end
      FPKG_LOCKED_OUT: begin
        state_nxt = FPKG_LOCKED_OUT;
      end
      default: begin
        state_nxt = FPKG_LOCKED_OUT;
      end
    endcase
  end

  // State register, back to idle on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= FPKG_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign g.unlocked = (state_r == FPKG_UNLOCKED);
  assign g.state = state_r;
endmodule
`default_nettype wire

/* File: core/fpkg_top.sv */
// Purpose: Flash write/erase gating and sequencing for in-system programming
// Assumes: Registers over AXI4-Lite, one 20 MHz clock, synchronous reset
// Notes: Flash array is modelled here; device reset is requested, not done
//
// Overview of operation
// - Programming only clears bits; erase sets them.
// - Hardware times every write and erase.
// - Core write stalls while an operation runs.
// - Core write address and data give target.
// - Write enable set routes core writes to flash.
// - Write enable holds until software clears it.
// - Keys 0xA5 then 0xF1 unlock one operation.
// - Any spacing between the two keys is fine.
// - Wrong or misordered key locks out until reset.
// - Operation before full key sequence locks out.
// - Gate relocks after each completed software operation.
// - Attempt without supply monitor reset causes error reset.
// - Uninitialised flash programmable only by debug port.
// - Erase needs both write and erase enable.
// - Erase sets whole 1024-byte page to 0xFF.
// - Any write inside a page erases that page.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`include "fpkg_regs.svh"
`default_nettype none
module fpkg_top
  import fpkg_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = `FPKG_ERASE_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core external_data_move write port
  input wire logic xd_wr_valid,
  output logic xd_wr_ready,
  input wire logic [15:0] xd_wr_addr,
  input wire logic [7:0] xd_wr_data,
  // Data memory write port
  output logic xram_wr_en,
  output logic [15:0] xram_wr_addr,
  output logic [7:0] xram_wr_data,
  // Flash read port for code fetch
  input wire logic [11:0] flash_rd_addr,
  output logic [7:0] flash_rd_data,
  // two_wire_debug_port programming requests
  input wire logic dbg_valid,
  output logic dbg_ready,
  input wire logic dbg_erase,
  input wire logic [11:0] dbg_addr,
  input wire logic [7:0] dbg_data,
  // Flash initialised strap pin
  input wire logic flash_initialized,
  // Flash-error device reset request
  output logic flash_error_reset
);
  localparam int unsigned WRITE_CYCLES = `FPKG_WRITE_CYCLES;

  fpkg_gate_if gif ();

  logic [7:0] flash_mem [`FPKG_FLASH_BYTES];
  logic [1:0] program_store_control_r;
  logic [1:0] supply_r;
  logic ferr_seen_r;
  logic init_m_r;
  logic init_s_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic busy_r;
  fpkg_op_t op_kind_r;
  logic op_sw_r;
  logic [11:0] op_addr_r;
  logic [7:0] op_data_r;
  logic [18:0] cnt_r;
  logic xram_en_r;
  logic [15:0] xram_addr_r;
  logic [7:0] xram_data_r;
  logic [7:0] rd_data_r;
  logic ferr_r;

  // Strap crosses from the pin domain through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_m_r <= 1'b0;
      init_s_r <= 1'b0;
    end else begin
      init_m_r <= flash_initialized;
      init_s_r <= init_m_r;
    end
  end

  // AXI write decode; address and data are taken together
  wire aw_take = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  wire w_lane0 = s_axi_wstrb[0];
  wire w_program_store_control = aw_take && (s_axi_awaddr == `FPKG_OFF_PROGRAM_STORE_CONTROL);
  wire w_key = aw_take && (s_axi_awaddr == `FPKG_OFF_KEY);
  wire w_supply = aw_take && (s_axi_awaddr == `FPKG_OFF_SUPPLY);
  wire w_mapped = w_program_store_control || w_key || w_supply ||
                  (aw_take && (s_axi_awaddr == `FPKG_OFF_STATUS));
  assign s_axi_awready = aw_take;
  assign s_axi_wready = aw_take;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // AXI read decode
  wire ar_take = s_axi_arvalid && !rvalid_r;
  wire gate_locked = (gif.state == FPKG_LOCKED_OUT);
  logic [31:0] status_word;

  // Status packed from the field positions; spare bits read zero
  always_comb begin
    status_word = 32'h0;
    status_word[`FPKG_ST_BUSY_BIT] = busy_r;
    status_word[`FPKG_ST_GATE_LSB +: 2] = gif.state;
    status_word[`FPKG_ST_LOCK_BIT] = gate_locked;
    status_word[`FPKG_ST_FERR_BIT] = ferr_seen_r;
    status_word[`FPKG_ST_INIT_BIT] = init_s_r;
  end

  // Read address decode
  wire r_mapped = (s_axi_araddr == `FPKG_OFF_PROGRAM_STORE_CONTROL) ||
                  (s_axi_araddr == `FPKG_OFF_KEY) ||
                  (s_axi_araddr == `FPKG_OFF_SUPPLY) ||
                  (s_axi_araddr == `FPKG_OFF_STATUS);
  wire [31:0] r_word = (s_axi_araddr == `FPKG_OFF_PROGRAM_STORE_CONTROL) ? {30'h0, program_store_control_r} :
                       (s_axi_araddr == `FPKG_OFF_SUPPLY) ? {30'h0, supply_r} :
                       (s_axi_araddr == `FPKG_OFF_STATUS) ? status_word : 32'h0;
  assign s_axi_arready = ar_take;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Write and erase enable bits change only by software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_store_control_r <= `FPKG_PROGRAM_STORE_CONTROL_RESET;
      supply_r <= `FPKG_SUPPLY_RESET;
    end else begin
      if (w_program_store_control && w_lane0) begin
        program_store_control_r <= s_axi_wdata[1:0];
      end
      if (w_supply && w_lane0) begin
        supply_r <= s_axi_wdata[1:0];
      end
    end
  end

  // Write response; unmapped addresses answer with slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `FPKG_RESP_OKAY;
    end else if (aw_take) begin
      bvalid_r <= 1'b1;
      bresp_r <= w_mapped ? `FPKG_RESP_OKAY : `FPKG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read response; the key register reads as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= `FPKG_RESP_OKAY;
      rdata_r <= 32'h0;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rresp_r <= r_mapped ? `FPKG_RESP_OKAY : `FPKG_RESP_SLVERR;
      rdata_r <= r_word;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Core write routing and attempt classification
  wire program_store_write_enable = program_store_control_r[`FPKG_PROGRAM_STORE_CONTROL_WE_BIT];
  wire program_store_erase_enable = program_store_control_r[`FPKG_PROGRAM_STORE_CONTROL_EE_BIT];
  wire monitor_ok = supply_r[`FPKG_SUP_EN_BIT] && supply_r[`FPKG_SUP_RST_BIT];
  wire xd_fire = xd_wr_valid && xd_wr_ready;
  wire to_xram = xd_fire && !program_store_write_enable;
  wire sw_attempt = xd_fire && program_store_write_enable;
  wire sw_fault = sw_attempt && !monitor_ok;
  wire sw_try = sw_attempt && monitor_ok && init_s_r;
  wire sw_start = sw_try && gif.unlocked;
  wire sw_erase = program_store_erase_enable && program_store_write_enable;
  wire dbg_start = dbg_valid && dbg_ready;
  wire [18:0] op_last = (op_kind_r == FPKG_OP_ERASE) ? 19'(ERASE_CYCLES - 1)
                                                     : 19'(WRITE_CYCLES - 1);
  wire op_end = busy_r && (cnt_r == op_last);

  // Only the low bits reach the 4096-byte flash; bits 15:12 are dropped
  wire [11:0] xd_flash_addr = xd_wr_addr[11:0];

  // Stall the core while an operation runs; core wins over debug port
  assign xd_wr_ready = !busy_r;
  assign dbg_ready = !busy_r && !xd_wr_valid;

  // Key gate hookup
  assign gif.key_wr = w_key && w_lane0;
  assign gif.key_val = s_axi_wdata[7:0];
  assign gif.attempt = sw_try;
  assign gif.done = op_end && op_sw_r;

  fpkg_key_gate i_fpkg_key_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .g(gif.gate)
  );

  // Operation sequencer; the timer alone decides completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      op_kind_r <= FPKG_OP_PROGRAM;
      op_sw_r <= 1'b0;
      op_addr_r <= 12'h0;
      op_data_r <= 8'h0;
      cnt_r <= 19'h0;
    end else if (!busy_r && (sw_start || dbg_start)) begin
      busy_r <= 1'b1;
      op_sw_r <= sw_start;
      cnt_r <= 19'h0;
      op_addr_r <= sw_start ? xd_flash_addr : dbg_addr;
      op_data_r <= sw_start ? xd_wr_data : dbg_data;
      op_kind_r <= (sw_start ? sw_erase : dbg_erase) ? FPKG_OP_ERASE
                                                     : FPKG_OP_PROGRAM;
    end else if (op_end) begin
      busy_r <= 1'b0;
      op_sw_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r + 19'h1;
    end
  end

  // Flash array write select; erase walks the page one byte a cycle
  wire erase_walk = (op_kind_r == FPKG_OP_ERASE) && (cnt_r < 19'(`FPKG_PAGE_BYTES));
  wire prog_write = (op_kind_r == FPKG_OP_PROGRAM) && (cnt_r == 19'h0);
  wire fl_we = busy_r && (erase_walk || prog_write);
  wire [11:0] fl_waddr = erase_walk ? {op_addr_r[11:10], cnt_r[9:0]} : op_addr_r;
  wire [7:0] fl_wdata = erase_walk ? `FPKG_ERASED_BYTE
                                   : (flash_mem[op_addr_r] & op_data_r);

  // Non-volatile array, deliberately not reset
  always_ff @(posedge aclk) begin
    if (fl_we) begin
      flash_mem[fl_waddr] <= fl_wdata;
    end
    rd_data_r <= flash_mem[flash_rd_addr];
  end

  // Data memory path and error reset request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xram_en_r <= 1'b0;
      xram_addr_r <= 16'h0;
      xram_data_r <= 8'h0;
      ferr_r <= 1'b0;
      ferr_seen_r <= 1'b0;
    end else begin
      xram_en_r <= to_xram;
      if (to_xram) begin
        xram_addr_r <= xd_wr_addr;
        xram_data_r <= xd_wr_data;
      end
      ferr_r <= sw_fault;
      if (sw_fault) begin
        ferr_seen_r <= 1'b1;
      end
    end
  end

  assign xram_wr_en = xram_en_r;
  assign xram_wr_addr = xram_addr_r;
  assign xram_wr_data = xram_data_r;
  assign flash_rd_data = rd_data_r;
  assign flash_error_reset = ferr_r;
endmodule
`default_nettype wire

/* File: bench/fpkg_top_props.sv */
// Purpose: Port-level checks of the flash key gate
// Assumes: Only the top ports are seen; control bits mirrored from bus writes
// Notes: Bench never writes registers and core at once
`include "fpkg_regs.svh"
`default_nettype none
module fpkg_top_props #(
  parameter int unsigned ERASE_CYCLES = 1100
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register writes
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  // Core and debug requests
  input wire logic xd_wr_valid,
  input wire logic xd_wr_ready,
  input wire logic [15:0] xd_wr_addr,
  input wire logic [7:0] xd_wr_data,
  input wire logic dbg_valid,
  input wire logic dbg_ready,
  // Results
  input wire logic xram_wr_en,
  input wire logic [15:0] xram_wr_addr,
  input wire logic [7:0] xram_wr_data,
  input wire logic flash_error_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  logic we_r;
  logic sup_r;
  logic [31:0] busy_r;
  // Decoded requests
  wire reg_wr = s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wstrb[0];
  wire take = xd_wr_valid && xd_wr_ready;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Mirror of write enable and supply settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      we_r <= 1'b0;
      sup_r <= 1'b0;
    end else if (reg_wr && s_axi_awaddr == `FPKG_OFF_PROGRAM_STORE_CONTROL) begin
      we_r <= s_axi_wdata[`FPKG_PROGRAM_STORE_CONTROL_WE_BIT];
    end else if (reg_wr && s_axi_awaddr == `FPKG_OFF_SUPPLY) begin
      sup_r <= &s_axi_wdata[1:0];
    end
  end
  // Length of the current stall, read when ready returns
  always_ff @(posedge aclk) begin
    busy_r <= xd_wr_ready ? 32'h0 : busy_r + 32'h1;
  end
  xram_route_a: assert property (
    take && !we_r |=> xram_wr_en && xram_wr_addr == $past(xd_wr_addr)
      && xram_wr_data == $past(xd_wr_data)) else $error("data memory write lost");
  xram_block_a: assert property (
    take && we_r |=> !xram_wr_en) else $error("flash write leaked to data memory");
  ready_fast_a: assert property (
    take && !we_r |=> xd_wr_ready) else $error("data memory write stalled");
  ferr_pulse_a: assert property (
    take && we_r && !sup_r |=> flash_error_reset) else $error("error reset missing");
  ferr_cause_a: assert property (
    !(take && we_r && !sup_r) |=> !flash_error_reset) else $error("spurious error reset");
  ferr_nostall_a: assert property (
    take && we_r && !sup_r |=> xd_wr_ready [*2]) else $error("faulted write started");
  busy_len_a: assert property (
    $rose(xd_wr_ready) |-> busy_r == `FPKG_WRITE_CYCLES || busy_r == ERASE_CYCLES)
    else $error("stall length wrong");
  dbg_prog_a: assert property (
    dbg_valid && dbg_ready |=> !xd_wr_ready) else $error("debug write did not start");
  // Main scenarios reached
  cover property (take && we_r && sup_r);
  cover property ($rose(xd_wr_ready) && busy_r == ERASE_CYCLES);
  cover property (flash_error_reset);
endmodule
bind fpkg_top fpkg_top_props #(.ERASE_CYCLES(ERASE_CYCLES)) i_fpkg_top_props (.*);
`default_nettype wire

/* File: bench/fpkg_core_model.sv */
// Purpose: Processor core issuing external data writes
// Assumes: Request held until ready is sampled high
// Notes: Released lines show inverted values
`default_nettype none
module fpkg_core_model (
  // Clock
  input wire logic aclk,
  // Write request
  input wire logic xd_wr_ready,
  output logic xd_wr_valid,
  output logic [15:0] xd_wr_addr,
  output logic [7:0] xd_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle at time zero
  initial begin
    xd_wr_valid = 1'b0;
    xd_wr_addr = 16'h0;
    xd_wr_data = 8'h0;
  end
  // One write; address and byte name the flash or data memory target
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    xd_wr_valid <= 1'b1;
    xd_wr_addr <= a;
    xd_wr_data <= d;
    do @(posedge aclk); while (xd_wr_ready !== 1'b1);
    xd_wr_valid <= 1'b0;
    xd_wr_addr <= ~a;
    xd_wr_data <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: bench/fpkg_top_tb.sv */
// Purpose: Self-checking bench of the flash key gate
// Assumes: Erase shortened to 1100 cycles
// Notes: Flash survives reset, so phases build on each other
`include "fpkg_regs.svh"
`default_nettype none
module fpkg_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] PS = `FPKG_OFF_PROGRAM_STORE_CONTROL;
  localparam logic [7:0] KY = `FPKG_OFF_KEY;
  localparam logic [7:0] SU = `FPKG_OFF_SUPPLY;
  localparam logic [7:0] ST = `FPKG_OFF_STATUS;
  localparam logic [7:0] K1 = `FPKG_KEY_FIRST;
  localparam logic [7:0] K2 = `FPKG_KEY_SECOND;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] e;} fpkg_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic xd_wr_valid, xd_wr_ready, xram_wr_en, dbg_valid, dbg_ready, dbg_erase;
  logic flash_initialized, flash_error_reset;
  logic [7:0] s_axi_awaddr, s_axi_araddr, xd_wr_data, xram_wr_data, flash_rd_data, dbg_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] xd_wr_addr, xram_wr_addr;
  logic [11:0] flash_rd_addr, dbg_addr;
  logic [23:0] xram_seen;
  int error_cnt = 0, checks = 0, cyc = 0, ferr_n = 0;
  // Register rows; unmapped places answer with an error
  fpkg_row_t rows [6] = '{'{PS, 32'h3, 32'h3, 2'h0}, '{PS, 32'hffffffff, 32'h3, 2'h0},
    '{SU, 32'h2, 32'h2, 2'h0}, '{SU, 32'h0, 32'h0, 2'h0}, '{PS, 32'h0, 32'h0, 2'h0},
    '{8'h10, 32'h1, 32'h0, 2'h2}};
  fpkg_top #(.ERASE_CYCLES(1100)) i_fpkg_top (.*);
  fpkg_core_model i_fpkg_core_model (.*);
  // Clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Bus write: address and data offered together, bready held until the answer
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", d, s_axi_rdata);
    chk("rresp", {30'h0, e}, {30'h0, s_axi_rresp});
  endtask
  task automatic keys(input logic [7:0] a, input logic [7:0] b);
    axw(KY, {24'h0, a});
    axw(KY, {24'h0, b});
  endtask
  // Core write, then wait out any stall
  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    i_fpkg_core_model.wr(a, d);
    do @(posedge aclk); while (xd_wr_ready !== 1'b1);
  endtask
  task automatic fchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge aclk);
    flash_rd_addr <= a;
    repeat (2) @(posedge aclk);
    chk("flash", {24'h0, e}, {24'h0, flash_rd_data});
  endtask
  task automatic rst(input logic s);
    @(posedge aclk);
    aresetn <= 1'b0;
    flash_initialized <= s;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // Watchdog and pulse monitors
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (flash_error_reset === 1'b1) ferr_n <= ferr_n + 1;
    if (xram_wr_en === 1'b1) xram_seen <= {xram_wr_addr, xram_wr_data};
    if (cyc == 20000) begin
      error_cnt++;
      end_sim;
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {aresetn, dbg_valid, dbg_erase, flash_initialized} = 4'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, dbg_addr, dbg_data, flash_rd_addr} = '0;
    s_axi_wstrb = 4'hf;
    rst(1'b1);
    axr(PS, 32'h0);
    axr(ST, 32'h20);
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].w, rows[i].e);
      axr(rows[i].a, rows[i].r, rows[i].e);
    end
    // Write enable clear: data memory, gate untouched
    xw(16'h8123, 8'h5a);
    axr(ST, 32'h20);
    chk("xram", 32'h0081235a, {8'h0, xram_seen});
    // Supply monitor off: error reset, no lockout
    axw(PS, 32'h1);
    xw(16'h0005, 8'h00);
    axr(ST, 32'h30);
    chk("ferr", 32'h1, 32'(ferr_n));
    // Keys with a gap, then page erase by any byte
    axw(SU, 32'h3);
    axw(PS, 32'h3);
    axw(KY, {24'h0, K1});
    axr(ST, 32'h32);
    repeat (20) @(posedge aclk);
    axw(KY, {24'h0, K2});
    axr(ST, 32'h34);
    xw(16'h0010, 8'h00);
    fchk(12'h000, 8'hff);
    fchk(12'h3ff, 8'hff);
    axr(ST, 32'h30);
    // Program twice: bits only clear
    axw(PS, 32'h1);
    keys(K1, K2);
    xw(16'h0005, 8'h3c);
    fchk(12'h005, 8'h3c);
    keys(K1, K2);
    xw(16'h0005, 8'hc3);
    fchk(12'h005, 8'h00);
    fchk(12'h004, 8'hff);
    // Attempt without keys locks out; later keys ignored
    xw(16'h0007, 8'h00);
    axr(ST, 32'h3e);
    keys(K1, K2);
    axr(ST, 32'h3e);
    xw(16'h0007, 8'h00);
    fchk(12'h007, 8'hff);
    // Out of order, then wrong second code
    for (int i = 0; i < 2; i++) begin
      rst(1'b1);
      keys(i ? K1 : K2, i ? 8'h00 : K1);
      axr(ST, 32'h2e);
    end
    // Uninitialised flash: software ignored, debug port programs
    rst(1'b0);
    axr(ST, 32'h00);
    axw(SU, 32'h3);
    axw(PS, 32'h1);
    keys(K1, K2);
    xw(16'h0008, 8'h00);
    fchk(12'h008, 8'hff);
    @(posedge aclk);
    dbg_valid <= 1'b1;
    dbg_addr <= 12'h006;
    dbg_data <= 8'h81;
    do @(posedge aclk); while (dbg_ready !== 1'b1);
    dbg_valid <= 1'b0;
    do @(posedge aclk); while (xd_wr_ready !== 1'b1);
    fchk(12'h006, 8'h81);
    end_sim;
  end
endmodule
`default_nettype wire
